/* File: core/apf_pkg.sv */
package apf_pkg;

  // Clock and sample pacing
  localparam real CLK_HZ = 125.0e6;
  localparam int SAMPLE_DIV = 256;
  localparam int TICK_BITS = $clog2(SAMPLE_DIV);
  localparam real SAMPLE_HZ = CLK_HZ / SAMPLE_DIV;
  localparam logic [1:0] SETTLE_SAMPLES = 2'h3;

  // Sample and datapath widths
  localparam int SAMPLE_BITS = 16;
  localparam int CHANNELS = 2;
  localparam logic signed [SAMPLE_BITS-1:0] SAMPLE_MAX = 16'sh7fff;
  localparam logic signed [SAMPLE_BITS-1:0] SAMPLE_MIN = 16'sh8000;
  localparam int PRODUCT_BITS = 32;
  localparam int ACC_BITS = 56;
  localparam int FIFO_DEFAULT_DEPTH = 8;

  // Filter corners; shift is the largest power of two not above fs/(2*pi*fc)
  localparam real TWO_PI = 6.2831853;
  localparam real HPF_CUTOFF_HZ = 4.45;
  localparam real LPF_CUTOFF_HZ = 8.9;
  localparam int HPF_SHIFT = $clog2(int'(SAMPLE_HZ / (TWO_PI * HPF_CUTOFF_HZ))) - 1;
  localparam int LPF_SHIFT = $clog2(int'(SAMPLE_HZ / (TWO_PI * LPF_CUTOFF_HZ))) - 1;
  localparam int HPF_ACC_BITS = SAMPLE_BITS + HPF_SHIFT + 3;
  localparam int LPF_ACC_BITS = PRODUCT_BITS + LPF_SHIFT + 2;

  // Power-up pulse suppression and pulse width
  localparam real HOLDOFF_S = 1.0;
  localparam int HOLDOFF_DEFAULT_CYCLES = int'(HOLDOFF_S * CLK_HZ);
  localparam real PULSE_WIDTH_US = 1.0;
  localparam int PULSE_CYCLES = int'(PULSE_WIDTH_US * CLK_HZ / 1.0e6);

  // Energy quantum for the slowest rate; each step of the two low rate pins halves it
  localparam logic [ACC_BITS-1:0] ENERGY_BASE = 56'h02_0000_0000_0000;
  localparam int THRESHOLD_MIN_SHIFT = 14;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_FILTER = 3'b001,
    ST_MULTIPLY = 3'b010,
    ST_AVERAGE = 3'b011,
    ST_ACCUMULATE = 3'b100
  } apf_stage_type;

  // Calibration quantum is the energy quantum divided by this power of two
  function automatic logic [3:0] apf_cal_shift(input logic [2:0] sel);
    case (sel)
      3'h0: return 4'h6;
      3'h1: return 4'h5;
      3'h2: return 4'h4;
      3'h3: return 4'hb;
      3'h4: return 4'h7;
      3'h5: return 4'h6;
      3'h6: return 4'h5;
      default: return 4'h4;
    endcase
  endfunction

endpackage

/* File: core/apf_stream_if.sv */
`timescale 1ns/10ps
interface apf_stream_if #(
  parameter int WIDTH = 32
);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport source (output valid, output data, input ready);
  modport sink (input valid, input data, output ready);
endinterface

/* File: core/apf_fifo.sv */
`timescale 1ns/10ps
module apf_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
)(
  // Clock, reset, enable
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clkEnable,
  input wire logic flush,
  // Streams
  apf_stream_if.sink inPort,
  apf_stream_if.source outPort
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (2 ** AW) != DEPTH) begin : gCheck
    $error("apf_fifo: DEPTH must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrIndex;
  logic [AW-1:0] rdIndex;
  logic [AW:0] count;

  wire full = (count == (AW+1)'(DEPTH));
  wire push = inPort.valid && inPort.ready && clkEnable;
  wire pop = outPort.valid && outPort.ready && clkEnable;

  assign inPort.ready = !full;
  assign outPort.valid = (count != '0);
  assign outPort.data = mem[rdIndex];

  always_ff @(posedge clk) begin
    if (push && !flush) begin
      mem[wrIndex] <= inPort.data;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wrIndex <= '0;
      rdIndex <= '0;
      count <= '0;
    end else if (clkEnable) begin
      if (flush) begin
        wrIndex <= '0;
        rdIndex <= '0;
        count <= '0;
      end else begin
        if (push) wrIndex <= wrIndex + 1'b1;
        if (pop) rdIndex <= rdIndex + 1'b1;
        if (push && !pop) count <= count + 1'b1;
        else if (pop && !push) count <= count - 1'b1;
      end
    end
  end

  a_fifo_fill_stall: assert property (@(posedge clk) disable iff (!reset_n)
    (push && !pop && !flush && count == (AW+1)'(DEPTH - 1)) |=> !inPort.ready && outPort.valid)
    else $error("fifo did not stall its source when it filled");

endmodule

/* File: core/apf_pulse_path.sv */
`timescale 1ns/10ps
// Operation
// - Supply below threshold acts as master clear.
// - No pulses for one second after power-up.
// - Each channel has its own high-pass filter.
// - Both high-pass filters are structurally identical.
// - Both filters step on the same clock.
// - High-pass corner sits near 4.45 Hz.
// - Low enable pin bypasses both filters together.
// - Multiplier forms product of filtered channels.
// - First-order IIR low-pass extracts average power.
// - Low-pass corner near 8.9 Hz, >20 dB.
// - Low-pass output accumulates continuously into converter.
// - Separate thresholds; one pulse per crossing.
// - Energy quantum much larger than calibration quantum.
// - Master clear holds channel codes at zero.
// - Samples every 256 clocks; first three discarded.
// - Two low rate pins select the energy quantum; all three select the calibration ratio.
module apf_pulse_path #(
  parameter int HOLDOFF_CYCLES = apf_pkg::HOLDOFF_DEFAULT_CYCLES,
  parameter int FIFO_DEPTH = apf_pkg::FIFO_DEFAULT_DEPTH,
  parameter logic [apf_pkg::ACC_BITS-1:0] ENERGY_THRESHOLD = apf_pkg::ENERGY_BASE
)(
  // Clock, reset, enable
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clkEnable,
  // Pins
  input wire logic masterClearN,
  input wire logic analogSupplyOk,
  input wire logic highPassEnablePin,
  input wire logic rateSelect0,
  input wire logic rateSelect1,
  input wire logic rateSelect2,
  // Sample stream from the converters
  input wire logic signed [apf_pkg::SAMPLE_BITS-1:0] currentSample,
  input wire logic signed [apf_pkg::SAMPLE_BITS-1:0] voltageSample,
  input wire logic sampleValid,
  output logic sampleReady,
  output logic sampleRequest,
  // Observed codes and power
  output logic signed [apf_pkg::SAMPLE_BITS-1:0] currentCode,
  output logic signed [apf_pkg::SAMPLE_BITS-1:0] voltageCode,
  output logic signed [apf_pkg::PRODUCT_BITS-1:0] activePower,
  // Pulse outputs
  output logic energyPulseOutA,
  output logic energyPulseOutB,
  output logic calibrationPulseOut
);
  import apf_pkg::*;

  localparam int HOLD_BITS = $clog2(HOLDOFF_CYCLES + 1);
  localparam int PULSE_BITS = $clog2(PULSE_CYCLES + 1);
  localparam int WORD_BITS = CHANNELS * SAMPLE_BITS;

  if (HOLDOFF_CYCLES < 1 || FIFO_DEPTH < 2) begin : gCheckCounts
    $error("apf_pulse_path: HOLDOFF_CYCLES and FIFO_DEPTH out of range");
  end
  if ((ENERGY_THRESHOLD >> THRESHOLD_MIN_SHIFT) == '0) begin : gCheckThreshold
    $error("apf_pulse_path: ENERGY_THRESHOLD too small for calibration quantum");
  end

  // Pin synchronisers
  logic [5:0] pinMeta;
  logic [5:0] pinSync;
  wire [5:0] pinsIn = {rateSelect2, rateSelect1, rateSelect0, highPassEnablePin, analogSupplyOk, masterClearN};

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pinMeta <= '0;
      pinSync <= '0;
    end else if (clkEnable) begin
      pinMeta <= pinsIn;
      pinSync <= pinMeta;
    end
  end

  wire syncClearN = pinSync[0];
  wire syncSupplyOk = pinSync[1];
  wire hpfOn = pinSync[2];
  wire [2:0] rateSel = pinSync[5:3];
  wire [1:0] rateLow = pinSync[4:3];

  // Brown-out clears like the clear pin and also restarts the holdoff
  wire chipClear = !syncClearN || !syncSupplyOk;

  // Holdoff restarts on every supply drop, so a bouncing supply never pulses
  logic [HOLD_BITS-1:0] holdoffCount;
  wire pulsesAllowed = (holdoffCount == '0);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      holdoffCount <= HOLD_BITS'(HOLDOFF_CYCLES);
    end else if (clkEnable) begin
      if (!syncSupplyOk) holdoffCount <= HOLD_BITS'(HOLDOFF_CYCLES);
      else if (!pulsesAllowed) holdoffCount <= holdoffCount - 1'b1;
    end
  end

  // Sample pacing
  logic [TICK_BITS-1:0] tickCount;
  assign sampleRequest = (tickCount == '0) && !chipClear;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) tickCount <= '0;
    else if (clkEnable) tickCount <= chipClear ? '0 : tickCount + 1'b1;
  end

  // Sample buffer
  apf_stream_if #(.WIDTH(WORD_BITS)) fifoIn ();
  apf_stream_if #(.WIDTH(WORD_BITS)) fifoOut ();

  assign fifoIn.valid = sampleValid && !chipClear;
  assign fifoIn.data = {voltageSample, currentSample};
  assign sampleReady = fifoIn.ready && !chipClear;

  apf_fifo #(.WIDTH(WORD_BITS), .DEPTH(FIFO_DEPTH)) sampleFifo (
    .clk(clk),
    .reset_n(reset_n),
    .clkEnable(clkEnable),
    .flush(chipClear),
    .inPort(fifoIn),
    .outPort(fifoOut)
  );

  // Processing sequence, one stage per enabled clock
  apf_stage_type stage;
  apf_stage_type next_stage;
  logic [1:0] settleCount;

  wire settling = (settleCount < SETTLE_SAMPLES);
  assign fifoOut.ready = (stage == ST_IDLE) && !chipClear && clkEnable;
  wire popTake = fifoOut.valid && fifoOut.ready;

  always_comb begin
    next_stage = stage;
    case (stage)
      ST_IDLE: if (popTake && !settling) next_stage = ST_FILTER;
      ST_FILTER: next_stage = ST_MULTIPLY;
      ST_MULTIPLY: next_stage = ST_AVERAGE;
      ST_AVERAGE: next_stage = ST_ACCUMULATE;
      ST_ACCUMULATE: next_stage = ST_IDLE;
      default: next_stage = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stage <= ST_IDLE;
      settleCount <= '0;
    end else if (clkEnable) begin
      if (chipClear) begin
        stage <= ST_IDLE;
        settleCount <= '0;
      end else begin
        stage <= next_stage;
        if (popTake && settling) settleCount <= settleCount + 1'b1;
      end
    end
  end

  // Channel filters, one generated copy per channel on the shared stage strobe
  logic signed [SAMPLE_BITS-1:0] chanRaw [CHANNELS];
  logic signed [SAMPLE_BITS-1:0] chanOut [CHANNELS];
  wire filterStep = (stage == ST_FILTER);

  for (genvar ch = 0; ch < CHANNELS; ch++) begin : gChan
    logic signed [SAMPLE_BITS-1:0] raw;
    logic signed [SAMPLE_BITS-1:0] prev;
    logic signed [SAMPLE_BITS-1:0] filtered;
    logic signed [HPF_ACC_BITS-1:0] acc;
    wire signed [SAMPLE_BITS-1:0] popSample = fifoOut.data[ch*SAMPLE_BITS +: SAMPLE_BITS];
    wire signed [HPF_ACC_BITS-1:0] rawWide = HPF_ACC_BITS'(raw);
    wire signed [HPF_ACC_BITS-1:0] prevWide = HPF_ACC_BITS'(prev);
    // Leaky differentiator: y += dx - y/2^k, corner set by the shift
    wire signed [HPF_ACC_BITS-1:0] next_acc = acc + ((rawWide - prevWide) <<< HPF_SHIFT) - (acc >>> HPF_SHIFT);
    wire signed [HPF_ACC_BITS-1:0] hpfValue = next_acc >>> HPF_SHIFT;
    wire hpfFits = (&hpfValue[HPF_ACC_BITS-1:SAMPLE_BITS-1]) || !(|hpfValue[HPF_ACC_BITS-1:SAMPLE_BITS-1]);
    wire signed [SAMPLE_BITS-1:0] hpfClamped =
      hpfFits ? hpfValue[SAMPLE_BITS-1:0] : (hpfValue[HPF_ACC_BITS-1] ? SAMPLE_MIN : SAMPLE_MAX);

    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        raw <= '0;
        prev <= '0;
        filtered <= '0;
        acc <= '0;
      end else if (clkEnable) begin
        if (chipClear) begin
          raw <= '0;
          prev <= '0;
          filtered <= '0;
          acc <= '0;
        end else begin
          if (popTake) raw <= popSample;
          if (filterStep) begin
            prev <= raw;
            acc <= next_acc;
            // Same register stage either way, so bypass keeps latency equal
            filtered <= hpfOn ? hpfClamped : raw;
          end
        end
      end
    end

    assign chanRaw[ch] = raw;
    assign chanOut[ch] = filtered;
  end

  assign currentCode = chanRaw[0];
  assign voltageCode = chanRaw[1];

  // Multiplier and average-power filter
  logic signed [PRODUCT_BITS-1:0] power;
  logic signed [LPF_ACC_BITS-1:0] avgAcc;
  wire signed [LPF_ACC_BITS-1:0] next_avgAcc = avgAcc + LPF_ACC_BITS'(power) - (avgAcc >>> LPF_SHIFT);
  wire signed [PRODUCT_BITS-1:0] avgPower = avgAcc[LPF_SHIFT +: PRODUCT_BITS];
  assign activePower = avgPower;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      power <= '0;
      avgAcc <= '0;
    end else if (clkEnable) begin
      if (chipClear) begin
        power <= '0;
        avgAcc <= '0;
      end else begin
        if (stage == ST_MULTIPLY) power <= PRODUCT_BITS'(chanOut[0]) * PRODUCT_BITS'(chanOut[1]);
        if (stage == ST_AVERAGE) avgAcc <= next_avgAcc;
      end
    end
  end

  // Pulse-rate converter: two accumulators, two quanta
  logic signed [ACC_BITS-1:0] energyAcc;
  logic signed [ACC_BITS-1:0] calAcc;
  wire signed [ACC_BITS-1:0] avgWide = ACC_BITS'(avgPower);
  wire signed [ACC_BITS-1:0] energyThreshold = signed'(ENERGY_THRESHOLD >> rateLow);
  wire signed [ACC_BITS-1:0] calThreshold = energyThreshold >>> apf_cal_shift(rateSel);
  wire signed [ACC_BITS-1:0] energySum = energyAcc + avgWide;
  wire signed [ACC_BITS-1:0] calSum = calAcc + avgWide;
  wire energyFire = (energySum >= energyThreshold);
  wire calFire = (calSum >= calThreshold);
  wire accStep = (stage == ST_ACCUMULATE);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      energyAcc <= '0;
      calAcc <= '0;
    end else if (clkEnable) begin
      if (chipClear) begin
        energyAcc <= '0;
        calAcc <= '0;
      end else if (accStep) begin
        energyAcc <= energyFire ? energySum - energyThreshold : energySum;
        calAcc <= calFire ? calSum - calThreshold : calSum;
      end
    end
  end

  // Pulse stretchers; energy pulses alternate between the two outputs
  logic [PULSE_BITS-1:0] energyPulseCount;
  logic [PULSE_BITS-1:0] calPulseCount;
  logic energyPhase;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      energyPulseCount <= '0;
      calPulseCount <= '0;
      energyPhase <= 1'b0;
    end else if (clkEnable) begin
      if (chipClear) begin
        energyPulseCount <= '0;
        calPulseCount <= '0;
        energyPhase <= 1'b0;
      end else begin
        if (accStep && energyFire && pulsesAllowed) begin
          energyPulseCount <= PULSE_BITS'(PULSE_CYCLES);
          energyPhase <= !energyPhase;
        end else if (energyPulseCount != '0) begin
          energyPulseCount <= energyPulseCount - 1'b1;
        end
        if (accStep && calFire && pulsesAllowed) calPulseCount <= PULSE_BITS'(PULSE_CYCLES);
        else if (calPulseCount != '0) calPulseCount <= calPulseCount - 1'b1;
      end
    end
  end

  wire energyActive = (energyPulseCount != '0) && pulsesAllowed;
  assign energyPulseOutA = energyActive && energyPhase;
  assign energyPulseOutB = energyActive && !energyPhase;
  assign calibrationPulseOut = (calPulseCount != '0) && pulsesAllowed;

  a_supply_clear: assert property (
    @(posedge clk) disable iff (!reset_n)
    (!syncSupplyOk && clkEnable) |-> !sampleReady ##1 (currentCode == '0 && voltageCode == '0))
    else $error("supply drop did not clear the path");

  a_holdoff_quiet: assert property (
    @(posedge clk) disable iff (!reset_n)
    !pulsesAllowed |-> (energyPulseCount == '0 && calPulseCount == '0 &&
      !(energyPulseOutA || energyPulseOutB || calibrationPulseOut)))
    else $error("pulse seen during power-up holdoff");

  a_clear_codes: assert property (
    @(posedge clk) disable iff (!reset_n)
    (chipClear && clkEnable) |=> (currentCode == '0 && voltageCode == '0 && stage == ST_IDLE))
    else $error("codes not zero under clear");

  a_request_period: assert property (
    @(posedge clk) disable iff (!reset_n || !clkEnable || chipClear)
    sampleRequest |-> ##256 sampleRequest)
    else $error("sample request period is not 256 clocks");

  a_settle_skip: assert property (
    @(posedge clk) disable iff (!reset_n)
    (popTake && settling && !chipClear) |=> (stage == ST_IDLE && settleCount == $past(settleCount) + 2'h1))
    else $error("settling sample was processed");

  a_bypass_equal: assert property (
    @(posedge clk) disable iff (!reset_n)
    (filterStep && clkEnable && !hpfOn && !chipClear) |=>
      (chanOut[0] == $past(chanRaw[0]) && chanOut[1] == $past(chanRaw[1])))
    else $error("bypass did not pass raw samples");

  a_product_value: assert property (
    @(posedge clk) disable iff (!reset_n)
    (stage == ST_MULTIPLY && clkEnable && !chipClear) |=>
      (power == PRODUCT_BITS'($past(chanOut[0])) * PRODUCT_BITS'($past(chanOut[1]))) && stage == ST_AVERAGE)
    else $error("multiplier output wrong");

  a_energy_remainder: assert property (
    @(posedge clk) disable iff (!reset_n)
    (accStep && clkEnable && !chipClear && energyFire) |=> (energyAcc == $past(energySum - energyThreshold)))
    else $error("remainder not kept after energy pulse");

  a_cal_finer: assert property (
    @(posedge clk) disable iff (!reset_n)
    (calThreshold < energyThreshold) && (calThreshold > '0))
    else $error("calibration quantum not below energy quantum");

  a_cal_pulse: assert property (
    @(posedge clk) disable iff (!reset_n)
    (accStep && calFire && pulsesAllowed && clkEnable && !chipClear) |=> calibrationPulseOut ##1 calibrationPulseOut)
    else $error("threshold crossing produced no calibration pulse");

endmodule

/* File: tb/apf_adc_source.sv */
`timescale 1ns/10ps
module apf_adc_source (
  // Clock
  input wire logic clk,
  // Sample stream
  output logic signed [apf_pkg::SAMPLE_BITS-1:0] currentSample,
  output logic signed [apf_pkg::SAMPLE_BITS-1:0] voltageSample,
  output logic sampleValid,
  input wire logic sampleReady,
  // Pulses
  input wire logic energyPulseOutA,
  input wire logic energyPulseOutB,
  input wire logic calibrationPulseOut
);
  import apf_pkg::*;
  int energyCount = 0;
  int calCount = 0;
  int repeatCount = 0;
  int refusals = 0;
  int calWidth = 0;
  int lastCalWidth = 0;
  logic stuck = 1'b0;
  logic [1:0] lastSide = 2'h0;
  logic prevA = 1'b0;
  logic prevB = 1'b0;
  logic prevCal = 1'b0;

  initial begin
    currentSample = 16'sh0000;
    voltageSample = 16'sh0000;
    sampleValid = 1'b0;
  end

  // Meter-side counter tallying the pulses
  always @(posedge clk) begin
    if (energyPulseOutA && !prevA) begin
      energyCount++;
      if (lastSide == 2'h1) repeatCount++;
      lastSide = 2'h1;
    end
    if (energyPulseOutB && !prevB) begin
      energyCount++;
      if (lastSide == 2'h2) repeatCount++;
      lastSide = 2'h2;
    end
    if (calibrationPulseOut && !prevCal) calCount++;
    if (prevCal && !calibrationPulseOut) lastCalWidth = calWidth;
    calWidth = calibrationPulseOut ? calWidth + 1 : 0;
    prevA = energyPulseOutA;
    prevB = energyPulseOutB;
    prevCal = calibrationPulseOut;
  end

  task automatic clear_counts();
    energyCount = 0;
    calCount = 0;
    repeatCount = 0;
    lastSide = 2'h0;
  endtask

  // Pair held until taken; released lines show inverted data, not stale values
  task automatic push(input logic signed [SAMPLE_BITS-1:0] cur, input logic signed [SAMPLE_BITS-1:0] volt);
    int n;
    @(negedge clk);
    currentSample = cur;
    voltageSample = volt;
    sampleValid = 1'b1;
    for (n = 0; n < 2000; n++) begin
      @(posedge clk);
      if (sampleReady === 1'b1) break;
      refusals++;
    end
    if (n == 2000) stuck = 1'b1;
    @(negedge clk);
    sampleValid = 1'b0;
    currentSample = ~cur;
    voltageSample = ~volt;
  endtask
endmodule

/* File: tb/apf_pulse_path_tb_top.sv */
`timescale 1ns/10ps
`define APF_CHECK(got, exp) \
  begin \
    compares++; \
    if ((got) !== (exp)) begin \
      mismatches++; \
      $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end

module apf_pulse_path_tb_top;
  import apf_pkg::*;
  // Short holdoff and small quantum keep the run brief
  localparam int HOLD = 3000;
  localparam logic [ACC_BITS-1:0] THRESH = 56'h00_0000_0010_0000;
  int mismatches = 0;
  int compares = 0;
  int cyc = 0;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic clkEnable = 1'b1;
  logic masterClearN = 1'b1;
  logic analogSupplyOk = 1'b1;
  logic highPassEnablePin = 1'b0;
  logic rateSelect0 = 1'b0;
  logic rateSelect1 = 1'b0;
  logic rateSelect2 = 1'b0;
  logic signed [SAMPLE_BITS-1:0] currentSample;
  logic signed [SAMPLE_BITS-1:0] voltageSample;
  logic sampleValid;
  logic sampleReady;
  logic sampleRequest;
  logic signed [SAMPLE_BITS-1:0] currentCode;
  logic signed [SAMPLE_BITS-1:0] voltageCode;
  logic signed [PRODUCT_BITS-1:0] activePower;
  logic energyPulseOutA;
  logic energyPulseOutB;
  logic calibrationPulseOut;

  always #4 clk = ~clk;
  always @(posedge clk) cyc++;

  apf_pulse_path #(.HOLDOFF_CYCLES(HOLD), .FIFO_DEPTH(8), .ENERGY_THRESHOLD(THRESH)) dut_u (
    .clk(clk), .reset_n(reset_n), .clkEnable(clkEnable),
    .masterClearN(masterClearN), .analogSupplyOk(analogSupplyOk), .highPassEnablePin(highPassEnablePin),
    .rateSelect0(rateSelect0), .rateSelect1(rateSelect1), .rateSelect2(rateSelect2),
    .currentSample(currentSample), .voltageSample(voltageSample), .sampleValid(sampleValid),
    .sampleReady(sampleReady), .sampleRequest(sampleRequest),
    .currentCode(currentCode), .voltageCode(voltageCode), .activePower(activePower),
    .energyPulseOutA(energyPulseOutA), .energyPulseOutB(energyPulseOutB),
    .calibrationPulseOut(calibrationPulseOut));

  apf_adc_source src_u (
    .clk(clk), .currentSample(currentSample), .voltageSample(voltageSample),
    .sampleValid(sampleValid), .sampleReady(sampleReady),
    .energyPulseOutA(energyPulseOutA), .energyPulseOutB(energyPulseOutB),
    .calibrationPulseOut(calibrationPulseOut));

  task automatic complete_run();
    if (mismatches == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic fail_wait();
    mismatches++;
    complete_run();
  endtask

  task automatic send(input logic signed [SAMPLE_BITS-1:0] c, input logic signed [SAMPLE_BITS-1:0] v);
    src_u.push(c, v);
    if (src_u.stuck !== 1'b0) fail_wait();
  endtask

  task automatic wait_request(output int waited);
    for (waited = 0; sampleRequest !== 1'b1; waited++) begin
      if (waited == 300) fail_wait();
      @(negedge clk);
    end
  endtask

  task automatic send_paced(input int n);
    int i;
    int w;
    for (i = 0; i < n; i++) begin
      wait_request(w);
      send(16'sh0800, 16'sh0800);
    end
  endtask

  task automatic check_settle_bypass();
    int i;
    for (i = 0; i < 3; i++) begin
      send(16'sh4000, 16'sh4000);
      repeat (2) @(posedge clk);
      @(negedge clk);
      `APF_CHECK(currentCode, 16'sh4000)
      `APF_CHECK(voltageCode, 16'sh4000)
      repeat (8) @(negedge clk);
      `APF_CHECK(activePower, 32'sh0000_0000)
    end
    send(16'sh4000, 16'sh4000);
    repeat (10) @(negedge clk);
    `APF_CHECK(activePower > 32'sh0000_0000, 1'b1)
    send(16'shc000, 16'sh4000);
    repeat (10) @(negedge clk);
    `APF_CHECK(activePower[31], 1'b1)
  endtask

  task automatic check_clear();
    masterClearN = 1'b0;
    repeat (4) @(negedge clk);
    `APF_CHECK(currentCode, 16'sh0000)
    `APF_CHECK(voltageCode, 16'sh0000)
    `APF_CHECK(sampleReady, 1'b0)
    masterClearN = 1'b1;
  endtask

  task automatic check_request_period();
    int w;
    wait_request(w);
    @(negedge clk);
    wait_request(w);
    `APF_CHECK(w + 1, SAMPLE_DIV)
    // Enable low must freeze the pacing counter at its strobe
    clkEnable = 1'b0;
    repeat (20) @(negedge clk);
    `APF_CHECK(sampleRequest, 1'b1)
    clkEnable = 1'b1;
    @(negedge clk);
    wait_request(w);
    `APF_CHECK(w + 1, SAMPLE_DIV)
  endtask

  task automatic check_holdoff();
    int t0;
    @(negedge clk);
    highPassEnablePin = 1'b1;
    analogSupplyOk = 1'b0;
    repeat (4) @(negedge clk);
    `APF_CHECK(sampleReady, 1'b0)
    `APF_CHECK(activePower, 32'sh0000_0000)
    analogSupplyOk = 1'b1;
    src_u.clear_counts();
    t0 = cyc;
    // Back-to-back pairs outrun the pipeline, so the buffer must refuse
    while (cyc - t0 < HOLD - 100) send(16'sh0800, 16'sh0800);
    `APF_CHECK(src_u.energyCount + src_u.calCount, 0)
    `APF_CHECK(src_u.refusals > 0, 1'b1)
    send_paced(20);
    `APF_CHECK(src_u.energyCount > 1, 1'b1)
    `APF_CHECK(src_u.calCount > src_u.energyCount, 1'b1)
    `APF_CHECK(src_u.repeatCount, 0)
    `APF_CHECK(src_u.lastCalWidth, PULSE_CYCLES)
  endtask

  task automatic check_rates();
    int sel;
    int ecount [8];
    for (sel = 0; sel < 8; sel++) begin
      {rateSelect2, rateSelect1, rateSelect0} = sel[2:0];
      send_paced(1);
      src_u.clear_counts();
      send_paced(6);
      ecount[sel] = src_u.energyCount;
      `APF_CHECK(src_u.calCount > 0, 1'b1)
    end
    `APF_CHECK(ecount[3] > ecount[0], 1'b1)
    `APF_CHECK(ecount[7] > ecount[4], 1'b1)
  endtask

  initial begin
    repeat (4) @(posedge clk);
    @(negedge clk);
    reset_n = 1'b1;
    repeat (3) @(negedge clk);
    check_settle_bypass();
    check_clear();
    check_request_period();
    check_holdoff();
    check_rates();
    `APF_CHECK(src_u.stuck, 1'b0)
    complete_run();
  end
endmodule
